// >>> core/mbs_pkg.sv
// Shared constants and carrier types of the matrix burst scheduler.
package mbs_pkg;

   // Clock rate and derived per-unit cycle counts.
   localparam int CLK_HZ = 10_000_000;
   localparam int CLK_PER_US = CLK_HZ / 1_000_000;
   localparam int CLK_PER_MS = CLK_HZ / 1_000;

   // Start-to-start burst periods.
   localparam int BURST_P0_US = 500;
   localparam int BURST_P1_US = 1000;
   localparam int BURST_P2_US = 2000;
   localparam int BURST_P0_CYC = BURST_P0_US * CLK_PER_US;
   localparam int BURST_P1_CYC = BURST_P1_US * CLK_PER_US;
   localparam int BURST_P2_CYC = BURST_P2_US * CLK_PER_US;

   // Calibration cycle length for each burst period.
   localparam int CAL_T0_MS = 100;
   localparam int CAL_T1_MS = 150;
   localparam int CAL_T2_MS = 300;
   localparam int CAL_T0_CYC = CAL_T0_MS * CLK_PER_MS;
   localparam int CAL_T1_CYC = CAL_T1_MS * CLK_PER_MS;
   localparam int CAL_T2_CYC = CAL_T2_MS * CLK_PER_MS;

   // Startup latencies before the host may talk to the block.
   localparam int BOOT_FIRST_MS = 2000;
   localparam int BOOT_MS = 70;
   localparam int BOOT_FIRST_CYC = BOOT_FIRST_MS * CLK_PER_MS;
   localparam int BOOT_CYC = BOOT_MS * CLK_PER_MS;

   // Least low time of the reset pin.
   localparam int RSTPIN_MIN_US = 10;
   localparam int RSTPIN_MIN_CYC = RSTPIN_MIN_US * CLK_PER_US;

   // Charge acceptance window, rounded up to whole cycles.
   localparam int DWELL_NS = 83;
   localparam int DWELL_CYC = (DWELL_NS * CLK_PER_US + 999) / 1000;

   // Pulse gap limits in microseconds.
   localparam int GAP_MIN_US = 1;
   localparam int GAP_MAX_US = 10;

   // Burst and calibration figures.
   localparam int NUM_KEYS = 16;
   localparam logic [6:0] PULSE_MAX = 7'h40;
   localparam logic [3:0] CAL_BURSTS = 4'h9;
   localparam logic [2:0] CAL_TRIES = 3'h5;
   localparam logic [11:0] RAMP_MAX = 12'hFFF;
   localparam logic [3:0] CLAMP_ALL = 4'hF;

   // Register offsets.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CAL = 8'h08;
   localparam logic [7:0] ADDR_RESULT = 8'h0C;
   localparam logic [7:0] ADDR_BLEN = 8'h40;
   localparam logic [7:0] BLEN_MASK = 8'hC3;

   // Field positions.
   localparam int CTRL_PER_LSB = 0;
   localparam int CTRL_GAP_LSB = 4;
   localparam int CTRL_RESTART_BIT = 8;
   localparam int ST_READY_BIT = 0;
   localparam int ST_CAL_BIT = 1;
   localparam int ST_ERR_BIT = 2;
   localparam int ST_KEY_LSB = 4;
   localparam int ST_SCAN_LSB = 8;
   localparam int RES_KEY_LSB = 12;
   localparam int RES_TMO_BIT = 16;

   // Period select codes and reset values.
   localparam logic [1:0] PER_SEL_500US = 2'h0;
   localparam logic [1:0] PER_SEL_1MS = 2'h1;
   localparam logic [1:0] PER_RST = 2'h0;
   localparam logic [3:0] GAP_RST = 4'h1;
   localparam logic [6:0] BLEN_RST = 7'h08;

   typedef enum logic [1:0] {
      SC_IDLE = 2'b00,
      SC_PULSE = 2'b01,
      SC_CONV = 2'b11,
      SC_WAIT = 2'b10
   } mbs_scan_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } mbs_apb_req_s;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } mbs_apb_rsp_s;

   typedef struct packed {
      logic [3:0] rowDrive;
      logic [3:0] colGate;
      logic [3:0] colClamp;
      logic rampEnable;
   } mbs_matrix_s;

endpackage

// >>> core/mbs_restart.sv
// Reset pin filter, restart command and startup latency timer.
module mbs_restart #(
   parameter int P_BOOT_FIRST = mbs_pkg::BOOT_FIRST_CYC,
   parameter int P_BOOT = mbs_pkg::BOOT_CYC
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic resetPinN,
   input wire logic softCmd,
   input wire logic nvBlank,
   output logic restartHold,
   output logic commReady
);
   import mbs_pkg::*;

   typedef struct packed {
      logic [7:0] pinLow;
      logic hold;
      logic [31:0] bootTimer;
      logic booting;
      logic seen;
      logic longBoot;
      logic ready;
   } mbs_rst_s;

   mbs_rst_s s;
   mbs_rst_s n;
   logic [31:0] target;

   // The blank-store strap is caught on the first edge after release,
   // so the asynchronous reset never loads a port value.
   always_comb begin
      n = s;
      n.hold = 1'b0;
      target = s.longBoot ? 32'(P_BOOT_FIRST) : 32'(P_BOOT);
      if (!s.seen) begin
         n.seen = 1'b1;
         n.longBoot = nvBlank;
         n.booting = 1'b1;
      end
      // Short glitches on the pin are ignored; only a long low restarts.
      if (!resetPinN) begin
         if (s.pinLow < 8'(RSTPIN_MIN_CYC)) begin
            n.pinLow = s.pinLow + 8'h1;
         end
         if (s.pinLow >= 8'(RSTPIN_MIN_CYC - 1)) begin
            n.hold = 1'b1;
         end
      end else begin
         n.pinLow = 8'h0;
      end
      if (softCmd) begin
         n.hold = 1'b1;
      end
      if (n.hold) begin
         n.ready = 1'b0;
         n.booting = 1'b1;
         n.bootTimer = 32'h0;
      end else if (s.booting && s.seen) begin
         n.bootTimer = s.bootTimer + 32'h1;
         if (s.bootTimer >= target - 32'h1) begin
            n.booting = 1'b0;
            n.ready = 1'b1;
            n.longBoot = 1'b0;
         end
      end
   end

   // State register.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign restartHold = s.hold;
   assign commReady = s.ready;

endmodule

// >>> core/mbs_scheduler.sv
// Burst scheduler for a 16-key capacitive matrix, with APB registers.
//
// Added by the designer: the register offsets and the APB slave port.
module mbs_scheduler #(
   parameter int P_BURST0 = mbs_pkg::BURST_P0_CYC,
   parameter int P_BURST1 = mbs_pkg::BURST_P1_CYC,
   parameter int P_BURST2 = mbs_pkg::BURST_P2_CYC,
   parameter int P_CAL0 = mbs_pkg::CAL_T0_CYC,
   parameter int P_CAL1 = mbs_pkg::CAL_T1_CYC,
   parameter int P_CAL2 = mbs_pkg::CAL_T2_CYC,
   parameter int P_BOOT_FIRST = mbs_pkg::BOOT_FIRST_CYC,
   parameter int P_BOOT = mbs_pkg::BOOT_CYC
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic resetPinN,
   input wire logic nvBlank,
   input wire logic rampTrip,
   input wire mbs_pkg::mbs_apb_req_s apbReq,
   output mbs_pkg::mbs_apb_rsp_s apbRsp,
   output mbs_pkg::mbs_matrix_s matrix,
   output logic commReady
);
   import mbs_pkg::*;

   typedef struct packed {
      mbs_apb_rsp_s rsp;
      logic softCmd;
      logic [1:0] perSel;
      logic [3:0] gapUs;
      logic [15:0][6:0] blen;
      logic running;
      mbs_scan_e scan;
      logic [3:0] key;
      logic [6:0] pulseIdx;
      logic [6:0] tick;
      logic [31:0] slotCnt;
      logic [11:0] rampCnt;
      logic [11:0] result;
      logic [3:0] resKey;
      logic resTimeout;
      logic [31:0] calTimer;
      logic [15:0] calib;
      logic [15:0] calErr;
      logic [15:0] calFail;
      logic [15:0][3:0] calBursts;
      logic [15:0][2:0] calTries;
      mbs_matrix_s pins;
   } mbs_state_s;

   // Power-on contents; the restart command loads the same value.
   function automatic mbs_state_s initState();
      mbs_state_s v;
      v = '0;
      v.perSel = PER_RST;
      v.gapUs = GAP_RST;
      for (int k = 0; k < NUM_KEYS; k++) begin
         v.blen[k] = BLEN_RST;
      end
      v.scan = SC_IDLE;
      v.pins.colClamp = CLAMP_ALL;
      return v;
   endfunction

   localparam mbs_state_s ST_RESET = initState();

   // Start-to-start slot length for the selected period.
   function automatic logic [31:0] slotLen(input logic [1:0] sel);
      if (sel == PER_SEL_500US) begin
         return 32'(P_BURST0);
      end else if (sel == PER_SEL_1MS) begin
         return 32'(P_BURST1);
      end
      return 32'(P_BURST2);
   endfunction

   // Calibration cycle length for the selected period.
   function automatic logic [31:0] calLen(input logic [1:0] sel);
      if (sel == PER_SEL_500US) begin
         return 32'(P_CAL0);
      end else if (sel == PER_SEL_1MS) begin
         return 32'(P_CAL1);
      end
      return 32'(P_CAL2);
   endfunction

   // Pulse spacing in cycles; settings outside 1..10 us are clipped.
   function automatic logic [6:0] gapLen(input logic [3:0] us);
      logic [3:0] u;
      u = us;
      if (u < 4'(GAP_MIN_US)) begin
         u = 4'(GAP_MIN_US);
      end else if (u > 4'(GAP_MAX_US)) begin
         u = 4'(GAP_MAX_US);
      end
      return 7'(int'(u) * CLK_PER_US);
   endfunction

   // One-hot line select.
   function automatic logic [3:0] oneHot(input logic [1:0] i);
      return 4'(4'h1 << i);
   endfunction

   // Pulse-count register decode, used by read and write paths.
   function automatic logic isBlen(input logic [7:0] a);
      return (a & BLEN_MASK) == ADDR_BLEN;
   endfunction

   // Matrix pin levels for a given scan state and pulse phase.
   function automatic mbs_matrix_s pinsFor(input mbs_scan_e sc,
                                           input logic [3:0] key,
                                           input logic [6:0] tick);
      mbs_matrix_s p;
      logic [3:0] row;
      logic [3:0] col;
      row = oneHot(key[1:0]);
      col = oneHot(key[3:2]);
      p.rowDrive = 4'h0;
      p.colGate = 4'h0;
      p.colClamp = CLAMP_ALL;
      p.rampEnable = 1'b0;
      if (sc == SC_PULSE) begin
         if (tick < 7'(DWELL_CYC)) begin
            p.rowDrive = row;
            p.colGate = col;
            p.colClamp = ~col;
         end else if (tick == 7'(DWELL_CYC)) begin
            p.rowDrive = row;
         end else if (tick == 7'(DWELL_CYC + 1)) begin
            p.colClamp = CLAMP_ALL;
         end else begin
            p.colClamp = ~col;
         end
      end else if (sc == SC_CONV) begin
         p.rampEnable = 1'b1;
         p.colClamp = ~col;
      end
      return p;
   endfunction

   mbs_state_s s;
   mbs_state_s n;
   logic restartHold;
   logic [31:0] per;
   logic [31:0] cal;
   logic [6:0] gap;
   logic acc;
   logic wr;
   logic hit;
   logic [31:0] rd;
   logic record;
   logic fail;

   // Restart sources and startup latency live in their own module.
   mbs_restart #(
      .P_BOOT_FIRST(P_BOOT_FIRST),
      .P_BOOT(P_BOOT)
   ) uRestart (
      .clk_sys(clk_sys),
      .rst(rst),
      .resetPinN(resetPinN),
      .softCmd(s.softCmd),
      .nvBlank(nvBlank),
      .restartHold(restartHold),
      .commReady(commReady)
   );

   // Next-state logic: bus slave, scan engine and calibration tracker.
   always_comb begin
      n = s;
      per = slotLen(s.perSel);
      cal = calLen(s.perSel);
      gap = gapLen(s.gapUs);
      record = 1'b0;
      fail = 1'b0;
      acc = apbReq.psel && apbReq.penable;
      wr = acc && s.rsp.pready && apbReq.pwrite;
      hit = 1'b1;
      rd = 32'h0;
      n.softCmd = 1'b0;

      // Read mux; the answer is registered, giving one wait state.
      if (isBlen(apbReq.paddr)) begin
         rd[6:0] = s.blen[apbReq.paddr[5:2]];
      end else begin
         case (apbReq.paddr)
            ADDR_CTRL: begin
               rd[CTRL_PER_LSB +: 2] = s.perSel;
               rd[CTRL_GAP_LSB +: 4] = s.gapUs;
            end
            ADDR_STATUS: begin
               rd[ST_READY_BIT] = commReady;
               rd[ST_CAL_BIT] = |s.calib;
               rd[ST_ERR_BIT] = |s.calErr;
               rd[ST_KEY_LSB +: 4] = s.key;
               rd[ST_SCAN_LSB +: 2] = s.scan;
            end
            ADDR_CAL: begin
               rd = {s.calErr, s.calib};
            end
            ADDR_RESULT: begin
               rd[11:0] = s.result;
               rd[RES_KEY_LSB +: 4] = s.resKey;
               rd[RES_TMO_BIT] = s.resTimeout;
            end
            default: begin
               hit = 1'b0;
            end
         endcase
      end
      n.rsp.pready = acc && !s.rsp.pready;
      n.rsp.pslverr = n.rsp.pready && !hit;
      if (n.rsp.pready) begin
         n.rsp.prdata = rd;
      end

      // Writes land on the edge that completes the access.
      if (wr && isBlen(apbReq.paddr)) begin
         if (apbReq.pwdata > 32'(PULSE_MAX)) begin
            n.blen[apbReq.paddr[5:2]] = PULSE_MAX;
         end else begin
            n.blen[apbReq.paddr[5:2]] = apbReq.pwdata[6:0];
         end
      end else if (wr && apbReq.paddr == ADDR_CTRL) begin
         n.perSel = apbReq.pwdata[CTRL_PER_LSB +: 2];
         n.gapUs = apbReq.pwdata[CTRL_GAP_LSB +: 4];
         n.softCmd = apbReq.pwdata[CTRL_RESTART_BIT];
      end

      // Scanning starts, with a full calibration, once the host may talk.
      if (!s.running) begin
         if (commReady) begin
            n.running = 1'b1;
            n.slotCnt = 32'h0;
            n.key = 4'h0;
            n.scan = SC_IDLE;
            n.calib = '1;
            n.calTimer = 32'h0;
         end
      end else begin
         n.slotCnt = s.slotCnt + 32'h1;
         unique case (s.scan)
            SC_IDLE: begin
               if (s.slotCnt == 32'h0) begin
                  if (s.blen[s.key] == 7'h0) begin
                     n.scan = SC_WAIT;
                     record = 1'b1;
                  end else begin
                     n.scan = SC_PULSE;
                     n.tick = 7'h0;
                     n.pulseIdx = 7'h0;
                  end
               end
            end
            SC_PULSE: begin
               if (s.tick >= gap - 7'h1) begin
                  n.tick = 7'h0;
                  n.pulseIdx = s.pulseIdx + 7'h1;
                  if (s.pulseIdx + 7'h1 >= s.blen[s.key]) begin
                     n.scan = SC_CONV;
                     n.rampCnt = 12'h0;
                  end
               end else begin
                  n.tick = s.tick + 7'h1;
               end
            end
            SC_CONV: begin
               n.rampCnt = s.rampCnt + 12'h1;
               if (rampTrip || s.rampCnt == RAMP_MAX) begin
                  n.result = s.rampCnt;
                  n.resKey = s.key;
                  n.resTimeout = !rampTrip;
                  n.scan = SC_WAIT;
                  record = 1'b1;
                  fail = !rampTrip;
               end
            end
            SC_WAIT: begin
               n.scan = SC_WAIT;
            end
         endcase
         // A burst that overruns its slot is cut short so that the
         // period never stretches; the host must size bursts to fit.
         if (s.slotCnt >= per - 32'h1) begin
            n.slotCnt = 32'h0;
            n.scan = SC_IDLE;
            n.key = s.key + 4'h1;
         end
      end

      // A finished or skipped slot counts as one calibration burst.
      if (record && s.calib[s.key]) begin
         if (s.calBursts[s.key] < CAL_BURSTS) begin
            n.calBursts[s.key] = s.calBursts[s.key] + 4'h1;
         end
         if (fail) begin
            n.calFail[s.key] = 1'b1;
         end
      end

      // At the end of each calibration cycle every pending key is judged.
      if (s.running && |s.calib) begin
         n.calTimer = s.calTimer + 32'h1;
         if (s.calTimer >= cal - 32'h1) begin
            n.calTimer = 32'h0;
            for (int k = 0; k < NUM_KEYS; k++) begin
               if (s.calib[k]) begin
                  if (n.calBursts[k] >= CAL_BURSTS && !n.calFail[k]) begin
                     n.calib[k] = 1'b0;
                  end else if (s.calTries[k] == CAL_TRIES - 3'h1) begin
                     n.calib[k] = 1'b0;
                     n.calErr[k] = 1'b1;
                  end else begin
                     n.calTries[k] = s.calTries[k] + 3'h1;
                  end
               end
               n.calBursts[k] = 4'h0;
               n.calFail[k] = 1'b0;
            end
         end
      end

      n.pins = pinsFor(n.scan, n.key, n.tick);

      // Pin reset and the restart command both reload power-on state.
      if (restartHold) begin
         n = ST_RESET;
      end
   end

   // State register.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s <= ST_RESET;
      end else begin
         s <= n;
      end
   end

   assign apbRsp = s.rsp;
   assign matrix = s.pins;

endmodule

// >>> verification/mbs_matrix_model.sv
// Model of the key matrix and ramp comparator at the scheduler's far side.
module mbs_matrix_model
   import mbs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire mbs_pkg::mbs_matrix_s matrix,
   input wire logic slowRamp,
   output logic rampTrip
);
   timeunit 1ns;
   timeprecision 1ns;
   int cyc;
   int npulse;
   int firstRise;
   int lastRise;
   int rampCnt;
   int gapSeen;
   logic [3:0] curKey;
   int keyQ[$];
   int startQ[$];
   int pulseQ[$];

   function automatic logic [1:0] ohIdx(input logic [3:0] v);
      ohIdx = 2'h0;
      for (int i = 0; i < 4; i++) begin
         if (v[i]) ohIdx = 2'(i);
      end
   endfunction

   // Each gated row rise is one transfer; a burst is logged at ramp start.
   // The comparator stays low outside a ramp, as the integrator is clamped.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cyc = 0;
         npulse = 0;
         rampCnt = 0;
         rampTrip <= 1'b0;
      end else begin
         cyc++;
         if (matrix.colGate != 4'h0) begin
            if (npulse == 0) begin
               firstRise = cyc;
               curKey = {ohIdx(matrix.colGate), ohIdx(matrix.rowDrive)};
            end else begin
               gapSeen = cyc - lastRise;
            end
            lastRise = cyc;
            npulse++;
         end
         if (matrix.rampEnable) begin
            if (rampCnt == 0 && npulse != 0) begin
               keyQ.push_back(int'(curKey));
               startQ.push_back(firstRise);
               pulseQ.push_back(npulse);
               npulse = 0;
            end
            rampCnt++;
            rampTrip <= (rampCnt > (slowRamp ? 40 : 3));
         end else begin
            rampCnt = 0;
            rampTrip <= 1'b0;
         end
      end
   end
endmodule

// >>> verification/mbs_scheduler_checker.sv
// Port checker of the matrix burst scheduler, bound to its top module.
module mbs_scheduler_checker
   import mbs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic resetPinN,
   input wire logic rampTrip,
   input wire mbs_pkg::mbs_apb_req_s apbReq,
   input wire mbs_pkg::mbs_apb_rsp_s apbRsp,
   input wire mbs_pkg::mbs_matrix_s matrix,
   input wire logic commReady
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] lowCnt;
   logic [7:0] next_lowCnt;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Counts low cycles of the reset pin; it saturates so it never wraps.
   always_comb begin
      next_lowCnt = lowCnt;
      if (resetPinN) begin
         next_lowCnt = 8'h00;
      end else if (lowCnt != 8'hFF) begin
         next_lowCnt = lowCnt + 8'h01;
      end
   end

   // Registers the low-time count.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lowCnt <= 8'h00;
      end else begin
         lowCnt <= next_lowCnt;
      end
   end

   // Drive, gate and ramp relations on the matrix side, and reset pin and readiness relations.
   row_onehot_a: assert property ($onehot0(matrix.rowDrive))
      else $error("Row drive is not one-hot.");
   gate_window_a: assert property (matrix.colGate != 4'h0 |->
      $past(matrix.rowDrive) == 4'h0 ##1 matrix.colGate == 4'h0)
      else $error("Charge gate not one cycle at the row rise.");
   gate_key_a: assert property (matrix.colGate != 4'h0 |->
      $onehot(matrix.colGate) && matrix.rowDrive != 4'h0 &&
      (matrix.colClamp & matrix.colGate) == 4'h0)
      else $error("Charge gate without its row or while clamped.");
   fall_clamp_a: assert property ($past(matrix.rowDrive) != 4'h0 &&
      matrix.rowDrive == 4'h0 |-> matrix.colClamp == CLAMP_ALL)
      else $error("Columns not grounded at the row fall.");
   ramp_quiet_a: assert property (matrix.rampEnable |->
      matrix.rowDrive == 4'h0 && matrix.colGate == 4'h0)
      else $error("Pulse during conversion.");
   ramp_stop_a: assert property (matrix.rampEnable && rampTrip |->
      ##[1:2] !matrix.rampEnable)
      else $error("Ramp kept running after the trip.");
   pin_restart_a: assert property (lowCnt > 8'h66 |->
      !commReady && matrix.rowDrive == 4'h0)
      else $error("Long reset pin pulse did not restart.");
   pin_short_a: assert property (commReady && !resetPinN &&
      lowCnt < 8'h60 |=> commReady)
      else $error("Short reset pin pulse dropped readiness.");
   boot_quiet_a: assert property (!commReady [*3] |->
      matrix.rowDrive == 4'h0)
      else $error("Scanning before the block is ready.");

   // Bus handshake relations.
   apb_wait_a: assert property ($rose(apbReq.psel && apbReq.penable) |=>
      apbRsp.pready)
      else $error("Bus answer not after one wait state.");
   err_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready)
      else $error("Bus error without ready.");
endmodule

bind mbs_scheduler mbs_scheduler_checker chk (
   .clk_sys(clk_sys),
   .rst(rst),
   .resetPinN(resetPinN),
   .rampTrip(rampTrip),
   .apbReq(apbReq),
   .apbRsp(apbRsp),
   .matrix(matrix),
   .commReady(commReady)
);

// >>> verification/tb.sv
// Self-checking bench of the matrix burst scheduler.
module tb
   import mbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SLOT0 = 200;
   localparam int SLOT1 = 400;
   localparam int SLOT2 = 800;
   localparam int CAL0 = 32000;
   localparam int BOOT1 = 300;
   localparam int BOOT = 100;
   logic clk_sys, rst, resetPinN, nvBlank, rampTrip, commReady, slowRamp;
   logic rerr;
   logic [31:0] rdata;
   mbs_apb_req_s apbReq;
   mbs_apb_rsp_s apbRsp;
   mbs_matrix_s matrix;
   int errors = 0;
   int cmpCount = 0;
   int cyc = 0;
   int tReady, n, m, slot;
   int expCnt[16];
   int gapIn[4] = '{0, 1, 10, 15};

   mbs_scheduler #(.P_BURST0(SLOT0), .P_BURST1(SLOT1), .P_BURST2(SLOT2),
      .P_CAL0(CAL0), .P_CAL1(2 * CAL0), .P_CAL2(4 * CAL0),
      .P_BOOT_FIRST(BOOT1), .P_BOOT(BOOT)) DUT (.clk_sys(clk_sys),
      .rst(rst), .resetPinN(resetPinN), .nvBlank(nvBlank),
      .rampTrip(rampTrip), .apbReq(apbReq), .apbRsp(apbRsp),
      .matrix(matrix), .commReady(commReady));
   mbs_matrix_model model (.clk_sys(clk_sys), .rst(rst), .matrix(matrix),
      .slowRamp(slowRamp), .rampTrip(rampTrip));

   // Clock source, 100 ns period.
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Cycle count; the ceiling cuts a hang short well past the planned run.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 95000) begin
         errors++;
         $display("[ERR] run length expected end seen hang");
         endOfTest();
      end
   end

   task automatic endOfTest();
      $display("Comparisons %0d, mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      cmpCount++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One bus transfer; the request holds until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] addr,
      input logic [31:0] data);
      int w;
      w = 0;
      @(posedge clk_sys);
      apbReq.psel <= 1'b1;
      apbReq.penable <= 1'b0;
      apbReq.pwrite <= wr;
      apbReq.paddr <= addr;
      apbReq.pwdata <= data;
      @(posedge clk_sys);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         w++;
      end while (apbRsp.pready !== 1'b1 && w < 50);
      rdata = apbRsp.prdata;
      rerr = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      if (w >= 50) check("pready", 32'h1, 32'h0);
   endtask

   task automatic rd(input string what, input logic [7:0] a,
      input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, exp, rdata);
   endtask

   task automatic waitCyc(input int c);
      repeat (c) @(posedge clk_sys);
   endtask

   // Waits, bounded, until readiness shows the given level.
   task automatic waitLevel(input logic lvl, output int c);
      c = 0;
      while (commReady !== lvl && c < 2000) begin
         @(posedge clk_sys);
         c++;
      end
   endtask

   task automatic setCounts();
      for (int k = 0; k < 16; k++) begin
         apb(1'b1, ADDR_BLEN + 8'(4 * k), 32'(expCnt[k]));
      end
   endtask

   task automatic clearLog();
      model.keyQ.delete();
      model.startQ.delete();
      model.pulseQ.delete();
   endtask

   // Key order, pulse counts and start-to-start spacing of logged bursts.
   task automatic scanCheck(input int s);
      int k, p, j;
      check("bursts", 32'h1, 32'(model.keyQ.size() > 8));
      for (int i = 0; i < model.keyQ.size(); i++) begin
         k = model.keyQ[i];
         check("pulses", expCnt[k], model.pulseQ[i]);
         if (i > 0) begin
            p = model.keyQ[i - 1];
            j = (p + 1) % 16;
            while (expCnt[j] == 0) j = (j + 1) % 16;
            check("nextKey", j, k);
            check("span", ((k - p + 16) % 16) * s,
               model.startQ[i] - model.startQ[i - 1]);
         end
      end
   endtask

   // Main sequence: each test is a run of bus calls and log checks.
   initial begin
      rst = 1'b1;
      resetPinN = 1'b1;
      nvBlank = 1'b1;
      slowRamp = 1'b0;
      apbReq = '0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      waitLevel(1'b1, n);
      tReady = cyc;
      check("bootFirst", 1, 32'(n >= BOOT1 && n <= BOOT1 + 4));
      rd("ctrlReset", ADDR_CTRL, 32'h0000_0010);
      rd("countReset", ADDR_BLEN, 32'h0000_0008);
      apb(1'b0, 8'hF0, 32'h0);
      check("unmapped", 32'h1, 32'(rerr));
      rd("calStart", ADDR_CAL, 32'h0000_FFFF);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("statusCal", 32'h3, rdata & 32'h7);
      $display("Test boot done");
      // Counts 0 to 15 give a skipped slot and a distinct count per key.
      for (int k = 0; k < 16; k++) expCnt[k] = k;
      setCounts();
      rd("countKey15", ADDR_BLEN + 8'h3C, 32'h0000_000F);
      waitCyc(2 * SLOT0);
      clearLog();
      waitCyc(33 * SLOT0);
      scanCheck(SLOT0);
      apb(1'b0, ADDR_RESULT, 32'h0);
      check("result", 32'h4, rdata & 32'h0001_0FFF);
      $display("Test scan done");
      waitCyc(tReady + CAL0 - 600 - cyc);
      rd("calBusy", ADDR_CAL, 32'h0000_FFFF);
      waitCyc(1000);
      rd("calDone", ADDR_CAL, 32'h0000_0000);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("statusDone", 32'h1, rdata & 32'h7);
      $display("Test calibration done");
      for (int s = 1; s < 4; s++) begin
         slot = (s == 1) ? SLOT1 : SLOT2;
         slowRamp <= (s == 3);
         apb(1'b1, ADDR_CTRL, 32'h0000_0010 | 32'(s));
         if (s == 2) begin
            expCnt[0] = 64;
            apb(1'b1, ADDR_BLEN, 32'h0000_0064);
            rd("countSat", ADDR_BLEN, 32'(PULSE_MAX));
         end
         waitCyc(2 * slot);
         clearLog();
         waitCyc(17 * slot);
         scanCheck(slot);
      end
      $display("Test period done");
      for (int k = 0; k < 16; k++) expCnt[k] = 3;
      setCounts();
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ADDR_CTRL, 32'(gapIn[i] * 16 + 2));
         waitCyc(2 * SLOT2);
         m = gapIn[i] < GAP_MIN_US ? GAP_MIN_US : gapIn[i];
         m = m > GAP_MAX_US ? GAP_MAX_US : m;
         check("gap", m * CLK_PER_US, model.gapSeen);
      end
      $display("Test gap done");
      apb(1'b1, ADDR_CTRL, 32'h0000_0100);
      waitLevel(1'b0, m);
      waitLevel(1'b1, n);
      check("softBoot", 1, 32'(m + n >= BOOT && m + n <= BOOT + 5));
      rd("ctrlSoft", ADDR_CTRL, 32'h0000_0010);
      rd("countSoft", ADDR_BLEN, 32'h0000_0008);
      $display("Test command restart done");
      apb(1'b1, ADDR_CTRL, 32'h0000_0013);
      resetPinN <= 1'b0;
      waitCyc(60);
      resetPinN <= 1'b1;
      waitCyc(3);
      check("shortPin", 32'h1, 32'(commReady));
      rd("ctrlKept", ADDR_CTRL, 32'h0000_0013);
      resetPinN <= 1'b0;
      waitCyc(RSTPIN_MIN_CYC + 10);
      resetPinN <= 1'b1;
      waitLevel(1'b1, n);
      check("pinBoot", 1, 32'(n >= BOOT && n <= BOOT + 4));
      rd("ctrlPin", ADDR_CTRL, 32'h0000_0010);
      $display("Test pin restart done");
      endOfTest();
   end
endmodule
